// ===== core_status_bank_regs.sv
// Core special-function registers: bank selector, status flags,
// program-counter low, table pointers and result, indirect pointers.
// Assumes the core decodes instructions and drives the access strobes.
`timescale 1ns/1ps
`include "core_sfr_map.svh"
module core_status_bank_regs
    import core_sfr_pkg::*;
#(
    parameter int THREE_BANKS = 1
)(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_wdt_sleep_reset,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_indirect,
    input wire logic i_ind_one,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire alu_op_t i_alu_op,
    input wire logic [7:0] i_alu_a,
    input wire logic [7:0] i_alu_b,
    input wire logic i_alu_cin,
    input wire logic i_rot_carry,
    input wire logic [7:0] i_logic_res,
    input wire logic i_wdt_timeout,
    input wire logic i_wdt_clear,
    input wire logic i_halt,
    input wire logic i_table_read,
    input wire logic [15:0] i_prog_word,
    input wire logic [7:0] i_gp_rdata,
    output logic [7:0] o_rdata,
    output logic [7:0] o_alu_res,
    output logic o_gp_sel,
    output logic o_gp_wr,
    output logic [1:0] o_gp_bank,
    output logic [7:0] o_gp_addr,
    output logic o_pc_load,
    output logic [7:0] o_pc_low,
    output logic o_dummy_cycle,
    output logic [15:0] o_table_addr,
    output logic [7:0] o_table_low,
    output logic [7:0] o_status
);
    localparam logic [1:0] BANK_MASK = (THREE_BANKS != 0) ? 2'h3 : 2'h1;

    logic [1:0] bank_r;
    logic [7:0] flags_r;
    logic [7:0] ptr_zero_r;
    logic [7:0] ptr_one_r;
    logic [7:0] work_r;
    logic [7:0] tbl_low_r;
    logic [7:0] tbl_high_r;
    logic [7:0] tbl_res_r;
    logic [7:0] pc_low_r;
    logic [7:0] table_low_r;
    logic pc_load_r;
    pc_state_t pc_state_r;
    logic [7:0] alu_res;
    logic [3:0] alu_flags;
    logic [3:0] alu_upd;
    logic [7:0] eff_addr;
    logic sfr_hit;
    logic bank_undef;
    logic [1:0] eff_bank;
    logic sfr_wr;

    // ------------------------------------------------------------------
    // Address resolution
    // ------------------------------------------------------------------
    always_comb begin
        eff_addr = i_indirect ? (i_ind_one ? ptr_one_r : ptr_zero_r)
                              : i_addr;
        eff_bank = (i_indirect && i_ind_one) ? bank_r : `BANK_RESET;
        sfr_hit = (eff_addr < `SFR_LIMIT);
        bank_undef = (eff_bank == `BANK_UNDEF);
        sfr_wr = i_wr && sfr_hit;
    end

    assign o_gp_sel = (i_wr || i_rd) && !sfr_hit && !bank_undef;
    assign o_gp_wr = i_wr && !sfr_hit && !bank_undef;
    assign o_gp_bank = eff_bank;
    assign o_gp_addr = eff_addr;

    // ------------------------------------------------------------------
    // Flag calculator
    // ------------------------------------------------------------------
    alu_flag_calc u_flags (
        .i_op(i_alu_op),
        .i_a(i_alu_a),
        .i_b(i_alu_b),
        .i_cin(i_alu_cin),
        .i_rot_carry(i_rot_carry),
        .i_logic_res(i_logic_res),
        .o_res(alu_res),
        .o_flags(alu_flags),
        .o_upd(alu_upd)
    );
    assign o_alu_res = alu_res;

    // ------------------------------------------------------------------
    // Bank selector
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            bank_r <= `BANK_RESET;
        end else if (i_wdt_sleep_reset) begin
            // watchdog sleep reset keeps bank
            // Core is held in reset here, so no write may land either
            bank_r <= bank_r;
        end else if (sfr_wr && eff_addr == `ADDR_BANK_SEL) begin
            bank_r <= i_wdata[1:0] & BANK_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            flags_r <= 8'h00;
        end else begin
            if (sfr_wr && eff_addr == `ADDR_FLAGS) begin
                flags_r[3:0] <= 4'(i_wdata & `FLAGS_RW_MASK);
            end else begin
                for (int i = 0; i < 4; i++) begin
                    if (alu_upd[i]) begin
                        flags_r[i] <= alu_flags[i];
                    end
                end
            end
            if (i_wdt_timeout) begin
                flags_r[`FLAG_WDOG] <= 1'b1;
            end else if (i_wdt_clear || i_halt) begin
                flags_r[`FLAG_WDOG] <= 1'b0;
            end
            if (i_halt) begin
                flags_r[`FLAG_SLEEP] <= 1'b1;
            end else if (i_wdt_clear) begin
                flags_r[`FLAG_SLEEP] <= 1'b0;
            end
            flags_r[7:6] <= 2'b00;
        end
    end
    assign o_status = flags_r;

    // ------------------------------------------------------------------
    // Pointers and working register
    // ------------------------------------------------------------------
    // moves through working reg
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ptr_zero_r <= 8'h00;
            ptr_one_r <= 8'h00;
            work_r <= 8'h00;
            tbl_low_r <= 8'h00;
            tbl_high_r <= 8'h00;
        end else if (sfr_wr) begin
            unique case (eff_addr)
                `ADDR_PTR_ZERO: ptr_zero_r <= i_wdata;
                `ADDR_PTR_ONE: ptr_one_r <= i_wdata;
                `ADDR_WORK_REG: work_r <= i_wdata;
                `ADDR_TBL_LOW: tbl_low_r <= i_wdata;
                `ADDR_TBL_HIGH: tbl_high_r <= i_wdata;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Table read
    // ------------------------------------------------------------------
    assign o_table_addr = {tbl_high_r, tbl_low_r};
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            tbl_res_r <= 8'h00;
            table_low_r <= 8'h00;
        end else if (i_table_read) begin
            tbl_res_r <= i_prog_word[15:8];
            table_low_r <= i_prog_word[7:0];
        end
    end
    assign o_table_low = table_low_r;

    // ------------------------------------------------------------------
    // Program counter low
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pc_low_r <= 8'h00;
            pc_load_r <= 1'b0;
            pc_state_r <= PC_RUN;
        end else begin
            pc_load_r <= 1'b0;
            unique case (pc_state_r)
                PC_RUN: begin
                    if (sfr_wr && eff_addr == `ADDR_PC_LOW) begin
                        pc_low_r <= i_wdata;
                        pc_load_r <= 1'b1;
                        pc_state_r <= PC_DUMMY;
                    end
                end
                PC_DUMMY: begin
                    pc_state_r <= PC_RUN;
                end
            endcase
        end
    end
    assign o_pc_load = pc_load_r;
    assign o_pc_low = pc_low_r;
    assign o_dummy_cycle = (pc_state_r == PC_DUMMY);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_comb begin
        o_rdata = 8'h00;
        if (!sfr_hit) begin
            o_rdata = bank_undef ? 8'h00 : i_gp_rdata;
        end else begin
            unique case (eff_addr)
                `ADDR_PTR_ZERO: o_rdata = ptr_zero_r;
                `ADDR_PTR_ONE: o_rdata = ptr_one_r;
                `ADDR_BANK_SEL: o_rdata = {6'h00, bank_r};
                `ADDR_WORK_REG: o_rdata = work_r;
                `ADDR_PC_LOW: o_rdata = pc_low_r;
                `ADDR_TBL_LOW: o_rdata = tbl_low_r;
                `ADDR_TBL_RES: o_rdata = tbl_res_r;
                `ADDR_TBL_HIGH: o_rdata = tbl_high_r;
                `ADDR_FLAGS: o_rdata = {2'b00, flags_r[5:0]};
                default: o_rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_pc_write;
        sfr_wr && eff_addr == `ADDR_PC_LOW && pc_state_r == PC_RUN;
    endsequence
    sequence s_jump_then_dummy;
        o_pc_load && o_dummy_cycle ##1 !o_dummy_cycle;
    endsequence

    a_pc_jump_dummy: assert property (@(posedge i_clk)
        disable iff (i_reset)
        s_pc_write |=> s_jump_then_dummy)
        else $error("pc jump lacks one dummy cycle");
    a_pc_low_value: assert property (@(posedge i_clk)
        disable iff (i_reset)
        s_pc_write |=> o_pc_low == $past(i_wdata))
        else $error("pc low not loaded");
    a_pc_refuse: assert property (@(posedge i_clk)
        disable iff (i_reset)
        sfr_wr && eff_addr == `ADDR_PC_LOW && pc_state_r == PC_DUMMY
            |=> !o_pc_load && $stable(o_pc_low))
        else $error("pc write taken in dummy cycle");
    a_wdog_set: assert property (@(posedge i_clk)
        disable iff (i_reset)
        i_wdt_timeout |=> o_status[`FLAG_WDOG])
        else $error("watchdog flag not set");
    a_wdog_clear: assert property (@(posedge i_clk)
        disable iff (i_reset)
        (i_wdt_clear || i_halt) && !i_wdt_timeout
            |=> !o_status[`FLAG_WDOG])
        else $error("watchdog flag not cleared");
    a_sleep_set: assert property (@(posedge i_clk)
        disable iff (i_reset)
        i_halt |=> o_status[`FLAG_SLEEP]
            && (!o_status[`FLAG_WDOG] || $past(i_wdt_timeout)))
        else $error("sleep flag not set on halt");
    a_sleep_clear: assert property (@(posedge i_clk)
        disable iff (i_reset)
        i_wdt_clear && !i_halt |=> !o_status[`FLAG_SLEEP])
        else $error("sleep flag not cleared");
    a_sys_flags_keep: assert property (@(posedge i_clk)
        disable iff (i_reset)
        (sfr_wr && eff_addr == `ADDR_FLAGS && !i_halt && !i_wdt_clear
            && !i_wdt_timeout) |=> $stable(o_status[5:4]))
        else $error("software changed system flags");
    a_flags_write: assert property (@(posedge i_clk)
        disable iff (i_reset)
        sfr_wr && eff_addr == `ADDR_FLAGS
            |=> o_status[3:0] == $past(i_wdata[3:0]))
        else $error("arithmetic flags not written");
    a_bank_direct: assert property (@(posedge i_clk)
        disable iff (i_reset)
        !i_indirect |-> o_gp_bank == 2'h0)
        else $error("direct access left bank zero");
    a_bank_indirect: assert property (@(posedge i_clk)
        disable iff (i_reset)
        i_indirect && i_ind_one |-> o_gp_bank == bank_r)
        else $error("pointer one ignored bank selector");
    a_bank_write: assert property (@(posedge i_clk)
        disable iff (i_reset)
        sfr_wr && eff_addr == `ADDR_BANK_SEL && !i_wdt_sleep_reset
            |=> bank_r == ($past(i_wdata[1:0]) & BANK_MASK))
        else $error("bank selector write wrong");
    a_bank_sleep_keep: assert property (@(posedge i_clk)
        disable iff (i_reset)
        i_wdt_sleep_reset |=> bank_r == $past(bank_r))
        else $error("bank changed by watchdog wake");
    a_sfr_shared: assert property (@(posedge i_clk)
        disable iff (i_reset)
        sfr_hit |-> !o_gp_sel && !o_gp_wr)
        else $error("register area reached memory");
    a_status_top: assert property (@(posedge i_clk)
        disable iff (i_reset)
        o_status[7:6] == 2'b00 ##1 o_status[7:6] == 2'b00)
        else $error("status top bits not zero");
    a_table_high: assert property (@(posedge i_clk)
        disable iff (i_reset)
        i_table_read |=> tbl_res_r == $past(i_prog_word[15:8]))
        else $error("table high byte wrong");
    a_table_low: assert property (@(posedge i_clk)
        disable iff (i_reset)
        i_table_read |=> o_table_low == $past(i_prog_word[7:0]))
        else $error("table low byte wrong");
    a_undef_bank: assert property (@(posedge i_clk)
        disable iff (i_reset)
        bank_undef && !sfr_hit |-> !o_gp_wr && o_rdata == 8'h00)
        else $error("undefined bank reached memory");
    a_zero_flag: assert property (@(posedge i_clk)
        disable iff (i_reset)
        i_alu_op == ALU_ADD && !sfr_wr && !(i_wr || i_rd)
            |=> o_status[`FLAG_ZERO] == ($past(alu_res) == 8'h00))
        else $error("zero flag wrong after add");
endmodule

// ===== core_sfr_map.svh
// Constants of the core special-function register bank: offsets, bit
// positions, reset values and write masks.
// Assumes a processor core that presents decoded data-memory accesses.
// How it works
// - Bank selector low two bits choose indirect bank zero to two.
// - Bank code 00, 01, 10 select banks zero, one, two; 11 undefined.
// - Any reset clears bank, except watchdog wake while powered down.
// - Special function area appears the same in every bank.
// - Direct addressing always reaches bank zero.
// - Two-bank variant keeps only bit 0; upper bits read zero.
// - Three-bank variant reads bits seven to two as zero; resets zero.
// - Writing program-counter low jumps within the current page.
// - Each such jump inserts one dummy instruction cycle.
// - Table read fetches word at pointer pair; high byte kept.
// - Software writes leave watchdog and sleep flags unchanged.
// - Watchdog flag set by time-out, cleared by power-up, clear, halt.
// - Sleep flag set by halt, cleared by power-up or watchdog clear.
// - Carry set on add carry or no subtract borrow; rotate updates.
// - Nibble carry set on low nibble carry or no nibble borrow.
// - Zero flag set when result is zero.
// - Signed-range flag set when carry into and out of MSB differ.
// - Status bits seven and six read zero; system flags reset zero.
// - Status is never saved automatically on call or interrupt.
// - No direct register-to-register move; data passes the working reg.
// - Second pointer uses bank selector; first pointer uses bank zero.
`ifndef CORE_SFR_MAP_SVH
`define CORE_SFR_MAP_SVH

`define ADDR_IND_ZERO 8'h00
`define ADDR_PTR_ZERO 8'h01
`define ADDR_IND_ONE 8'h02
`define ADDR_PTR_ONE 8'h03
`define ADDR_BANK_SEL 8'h04
`define ADDR_WORK_REG 8'h05
`define ADDR_PC_LOW 8'h06
`define ADDR_TBL_LOW 8'h07
`define ADDR_TBL_RES 8'h08
`define ADDR_TBL_HIGH 8'h09
`define ADDR_FLAGS 8'h0A
`define SFR_LIMIT 8'h40

`define FLAG_CARRY 0
`define FLAG_NIBBLE 1
`define FLAG_ZERO 2
`define FLAG_SIGNED 3
`define FLAG_SLEEP 4
`define FLAG_WDOG 5

`define BANK_RESET 2'h0
`define BANK_UNDEF 2'h3
`define FLAGS_RW_MASK 8'h0F

`endif

// ===== core_sfr_pkg.sv
// Types shared by the core special-function register bank.
// Assumes the map header is included by users of the constants.
package core_sfr_pkg;
    typedef enum logic [2:0] {
        ALU_NONE,
        ALU_ADD,
        ALU_SUB,
        ALU_LOGIC,
        ALU_ROT
    } alu_op_t;
    typedef enum logic [1:0] {
        PC_RUN,
        PC_DUMMY
    } pc_state_t;
endpackage

// ===== alu_flag_calc.sv
// Arithmetic flag calculator for one ALU operation.
// Assumes operands and carry-in come from the core on the same clock.
`timescale 1ns/1ps
`include "core_sfr_map.svh"
module alu_flag_calc
    import core_sfr_pkg::*;
(
    input wire alu_op_t i_op,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire logic i_cin,
    input wire logic i_rot_carry,
    input wire logic [7:0] i_logic_res,
    output logic [7:0] o_res,
    output logic [3:0] o_flags,
    output logic [3:0] o_upd
);
    logic [4:0] lo;
    logic [7:0] lo7;
    logic [8:0] full;
    logic [7:0] bb;
    logic c7;

    always_comb begin
        bb = (i_op == ALU_SUB) ? ~i_b : i_b;
        lo = {1'b0, i_a[3:0]} + {1'b0, bb[3:0]} + {4'h0, i_cin};
        lo7 = {1'b0, i_a[6:0]} + {1'b0, bb[6:0]} + {7'h00, i_cin};
        full = {1'b0, i_a} + {1'b0, bb} + {8'h00, i_cin};
        c7 = lo7[7];
        o_res = i_logic_res;
        o_flags = 4'h0;
        o_upd = 4'h0;
        unique case (i_op)
            ALU_ADD, ALU_SUB: begin
                o_res = full[7:0];
                o_flags[`FLAG_CARRY] = full[8];
                o_flags[`FLAG_NIBBLE] = lo[4];
                o_flags[`FLAG_ZERO] = (full[7:0] == 8'h00);
                o_flags[`FLAG_SIGNED] = c7 ^ full[8];
                o_upd = 4'hF;
            end
            ALU_LOGIC: begin
                o_flags[`FLAG_ZERO] = (i_logic_res == 8'h00);
                o_upd[`FLAG_ZERO] = 1'b1;
            end
            ALU_ROT: begin
                o_flags[`FLAG_CARRY] = i_rot_carry;
                o_upd[`FLAG_CARRY] = 1'b1;
            end
            ALU_NONE: begin
                o_upd = 4'h0;
            end
        endcase
    end
endmodule

// ===== core_side_model.sv
// Far side of the register bank: banked general memory and program memory.
// Assumes combinational access strobes and table address from the bank.
`timescale 1ns/1ps
module core_side_model (
    input wire logic i_clk,
    input wire logic i_sel,
    input wire logic i_wr,
    input wire logic [1:0] i_bank,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [15:0] i_table_addr,
    output logic [7:0] o_rdata,
    output logic [15:0] o_prog_word
);
    logic [7:0] mem_r [0:2][0:255];
    logic [7:0] last_r = 8'h00;
    logic hit;

    assign hit = i_sel && (i_bank != 2'h3);
    always @(posedge i_clk) begin
        if (hit && i_wr) begin
            mem_r[i_bank][i_addr] <= i_wdata;
        end
        if (i_sel && !i_wr) begin
            last_r <= o_rdata;
        end
    end
    // Unselected bus shows the inverse of its last value
    assign o_rdata = hit ? mem_r[i_bank][i_addr] : ~last_r;
    assign o_prog_word = {i_table_addr[7:0] ^ 8'hA5, ~i_table_addr[15:8]};
endmodule

// ===== core_status_bank_regs_tb.sv
// Self-checking bench for the core register bank.
// Assumes the far-side model answers memory and program reads.
`timescale 1ns/1ps
`include "core_sfr_map.svh"
`define CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); \
    end \
end
module core_status_bank_regs_tb
    import core_sfr_pkg::*;
;
    localparam logic H = 1'b1;
    localparam logic L = 1'b0;
    logic clk = 0, reset = 1, wsr = 0, wr = 0, rd = 0, ind = 0, one = 0;
    logic cin = 0, rotc = 0, wto = 0, wclr = 0, halt = 0, tread = 0;
    logic [7:0] addr = 0, wdata = 0, a_in = 0, b_in = 0, lres = 0;
    alu_op_t op = ALU_NONE;
    logic [15:0] pword, taddr;
    logic [7:0] gprd, rdata, ares, gaddr, prog_counter_low, tlow, status;
    logic gsel, gwr, pcld, dummy, gsel_q, gwr_q;
    logic [1:0] gbank, bank_q, sys = 0;
    logic [7:0] rd_q, gaddr_q, v, a, lo, hi;
    logic [3:0] flg = 0;
    logic [7:0] vals [0:2];
    int error_cnt = 0, comparisons = 0, cyc = 0;

    core_status_bank_regs #(.THREE_BANKS(1)) i_dut (
        .i_clk(clk), .i_reset(reset), .i_wdt_sleep_reset(wsr), .i_wr(wr),
        .i_rd(rd), .i_indirect(ind), .i_ind_one(one), .i_addr(addr),
        .i_wdata(wdata), .i_alu_op(op), .i_alu_a(a_in), .i_alu_b(b_in),
        .i_alu_cin(cin), .i_rot_carry(rotc), .i_logic_res(lres),
        .i_wdt_timeout(wto), .i_wdt_clear(wclr), .i_halt(halt),
        .i_table_read(tread), .i_prog_word(pword), .i_gp_rdata(gprd),
        .o_rdata(rdata), .o_alu_res(ares), .o_gp_sel(gsel), .o_gp_wr(gwr),
        .o_gp_bank(gbank), .o_gp_addr(gaddr), .o_pc_load(pcld),
        .o_pc_low(prog_counter_low), .o_dummy_cycle(dummy), .o_table_addr(taddr),
        .o_table_low(tlow), .o_status(status)
    );
    core_side_model i_far (
        .i_clk(clk), .i_sel(gsel), .i_wr(gwr), .i_bank(gbank),
        .i_addr(gaddr), .i_wdata(wdata), .i_table_addr(taddr),
        .o_rdata(gprd), .o_prog_word(pword)
    );

    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            wrap_up();
        end
    end

    // ----------------------------------------
    // Expected ALU result and flags
    // ----------------------------------------
    function automatic logic [11:0] alu_exp(input alu_op_t k,
        input logic [7:0] x, y, l, input logic c, r, input logic [3:0] f);
        logic [7:0] yy;
        logic [8:0] s;
        logic [4:0] n;
        logic [7:0] m;
        yy = (k == ALU_SUB) ? ~y : y;
        s = {1'b0, x} + {1'b0, yy} + 9'(c);
        n = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + 5'(c);
        m = {1'b0, x[6:0]} + {1'b0, yy[6:0]} + 8'(c);
        if (k == ALU_ADD || k == ALU_SUB) begin
            f = {m[7] ^ s[8], s[7:0] == 8'h00, n[4], s[8]};
        end else if (k == ALU_LOGIC) begin
            s = {1'b0, l};
            f[2] = (l == 8'h00);
        end else if (k == ALU_ROT) begin
            f[0] = r;
        end
        return {s[7:0], f};
    endfunction

    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    task automatic access(input logic w, p, o, input logic [7:0] ad, d);
        @(negedge clk);
        {wr, rd, ind, one, addr, wdata} = {w, !w, p, o, ad, d};
        #10;
        {rd_q, bank_q, gaddr_q, gsel_q} = {rdata, gbank, gaddr, gsel};
        gwr_q = gwr;
        @(negedge clk);
        {wr, rd, ind} = 3'h0;
    endtask
    task automatic pulse(input logic [4:0] e);
        @(negedge clk);
        {wsr, tread, wto, wclr, halt} = e;
        @(negedge clk);
        {wsr, tread, wto, wclr, halt} = 5'h00;
    endtask
    task automatic alu_run(input alu_op_t k, input logic [7:0] x, y);
        logic [11:0] e;
        @(negedge clk);
        op = k;
        {a_in, b_in, lres} = {x, y, 8'($urandom)};
        {cin, rotc} = {(k == ALU_SUB) ? 1'($urandom) : 1'b0, 1'($urandom)};
        e = alu_exp(k, x, y, lres, cin, rotc, flg);
        #10;
        if (k != ALU_ROT && k != ALU_NONE) `CHK(ares, e[11:4])
        @(negedge clk);
        op = ALU_NONE;
        flg = e[3:0];
        `CHK(status, {2'b00, sys, flg})
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h8948));
        repeat (8) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        access(L, L, L, `ADDR_BANK_SEL, 8'h00);
        `CHK(rd_q, 8'h00)
        `CHK(status, 8'h00)
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom);
            access(H, L, L, `ADDR_BANK_SEL, v);
            access(L, L, L, `ADDR_BANK_SEL, 8'h00);
            `CHK(rd_q, v & 8'h03)
        end
        $display("test reset and bank field done");
        // General memory only, clear of reserved places
        a = 8'h40 | 8'($urandom % 64);
        access(H, L, L, `ADDR_PTR_ONE, a);
        access(H, L, L, `ADDR_PTR_ZERO, a);
        for (int b = 0; b < 3; b++) begin
            vals[b] = 8'($urandom);
            access(H, L, L, `ADDR_BANK_SEL, 8'(b));
            access(H, H, H, 8'h00, vals[b]);
            `CHK({gsel_q, gwr_q, bank_q, gaddr_q}, {H, H, 2'(b), a})
        end
        for (int b = 0; b < 3; b++) begin
            access(H, L, L, `ADDR_BANK_SEL, 8'(b));
            access(L, H, H, 8'h00, 8'h00);
            `CHK(rd_q, vals[b])
            access(L, H, L, 8'h00, 8'h00);
            `CHK({bank_q, rd_q}, {2'h0, vals[0]})
            access(L, L, L, a, 8'h00);
            `CHK({bank_q, rd_q}, {2'h0, vals[0]})
        end
        access(H, L, L, `ADDR_BANK_SEL, 8'h03);
        access(L, H, H, 8'h00, 8'h00);
        `CHK(rd_q, 8'h00)
        access(H, H, H, 8'h00, 8'h5A);
        `CHK({gsel_q, gwr_q}, 2'b00)
        access(H, L, L, `ADDR_BANK_SEL, 8'h02);
        access(H, L, L, `ADDR_PTR_ONE, `ADDR_BANK_SEL);
        access(L, H, H, 8'h00, 8'h00);
        `CHK(rd_q, 8'h02)
        $display("test banks done");
        pulse(5'h10);
        access(L, L, L, `ADDR_BANK_SEL, 8'h00);
        `CHK(rd_q, 8'h02)
        @(negedge clk);
        reset = 1'b1;
        @(negedge clk);
        reset = 1'b0;
        access(L, L, L, `ADDR_BANK_SEL, 8'h00);
        `CHK(rd_q, 8'h00)
        `CHK(status, 8'h00)
        $display("test resets done");
        access(H, L, L, `ADDR_FLAGS, 8'hFF);
        `CHK(status, 8'h0F)
        pulse(5'h01);
        `CHK(status, 8'h1F)
        pulse(5'h04);
        `CHK(status, 8'h3F)
        access(H, L, L, `ADDR_FLAGS, 8'h00);
        access(L, L, L, `ADDR_FLAGS, 8'h00);
        `CHK(rd_q, 8'h30)
        pulse(5'h01);
        `CHK(status, 8'h10)
        pulse(5'h02);
        `CHK(status, 8'h00)
        $display("test system flags done");
        v = 8'($urandom);
        @(negedge clk);
        {wr, addr, wdata} = {H, `ADDR_PC_LOW, v};
        @(negedge clk);
        wdata = ~v;
        `CHK({pcld, dummy, prog_counter_low}, {2'b11, v})
        @(negedge clk);
        wr = 1'b0;
        `CHK({pcld, dummy, prog_counter_low}, {2'b00, v})
        $display("test program counter done");
        repeat (4) begin
            {lo, hi} = 16'($urandom);
            access(H, L, L, `ADDR_TBL_LOW, lo);
            access(H, L, L, `ADDR_TBL_HIGH, hi);
            `CHK(taddr, {hi, lo})
            pulse(5'h08);
            `CHK(tlow, ~hi)
            access(L, L, L, `ADDR_TBL_RES, 8'h00);
            `CHK(rd_q, lo ^ 8'hA5)
        end
        $display("test table read done");
        alu_run(ALU_ADD, 8'h80, 8'h80);
        alu_run(ALU_ADD, 8'h7F, 8'h01);
        alu_run(ALU_SUB, 8'h10, 8'h01);
        alu_run(ALU_LOGIC, 8'h00, 8'h00);
        repeat (60) begin
            alu_run(alu_op_t'($urandom % 5), 8'($urandom), 8'($urandom));
        end
        $display("test alu flags done");
        wrap_up();
    end
endmodule
